/* hdl/io_map_pkg.sv */
// Constants, types and carriers for the I/O register image and mode gate.
// Assumes one 100 MHz system clock and a word-aligned Avalon-MM slave port.
//
// How it works
// - Volatile-memory switch at power-up forces halt
// - Protected run blocks data word 0-4095 writes
// - Reload at power-on and run entry, gated
// - Reload copies program and data words 0-4095
// - Allocation accepted only halted, not protected
// - Auto allocation reads types into program memory
// - Type encodes direction class and word count
// - Records written trigger automatic address mapping
// - One shared image, direction per register
// - Unallocated registers behave as output registers
// - Image holds 256 sixteen-bit registers
// - Addresses 0-255, bit positions 0 to F
// - Card present: reload from card only
// - Mapping starts nearest slot, ascending addresses
// - Special module types occupy no registers
package io_map_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned IMG_WORDS = 256;   // Shared image depth
  localparam int unsigned PROT_WORDS = 4096; // Reloaded, protected data
  localparam int unsigned PROG_WORDS = 256;  // Program words, records first
  localparam int unsigned NSLOT = 44;        // Four units of eleven slots
  localparam int unsigned LOAD_WORDS = PROG_WORDS + PROT_WORDS;

  // ----------------------------------------------------------------
  // Byte address map (bit 14 selects the data words)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_IMAGE = 4'h0;  // Image words
  localparam logic [3:0] REG_DIR = 4'h1;    // Direction bit per word
  localparam logic [3:0] REG_PROG = 4'h2;   // Program / records
  localparam logic [3:0] REG_CTL = 4'h3;    // Control and status
  localparam logic [7:0] CTL_WORD = 8'h00;  // Command word
  localparam logic [7:0] STAT_WORD = 8'h01; // Status word

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_AUTO = 0;  // Automatic allocation
  localparam int unsigned CTL_RUN = 1;   // Run command
  localparam int unsigned CTL_HALT = 2;  // Halt command
  localparam int unsigned STAT_RUN = 0;  // Running
  localparam int unsigned STAT_PROT = 1; // Protected run selected
  localparam int unsigned STAT_BUSY = 2; // Engine busy
  localparam int unsigned STAT_REJ = 3;  // Sticky allocation rejected
  localparam int unsigned STAT_NV = 4;   // Memory switch non-volatile
  localparam int unsigned TYPE_SPECIAL = 5; // Type bit: special module

  // Direction class in type bits 7:6, word count in bits 3:0
  typedef enum logic [1:0] {
    CLS_NONE = 2'h0,
    CLS_IN = 2'h1,
    CLS_OUT = 2'h2,
    CLS_MIX = 2'h3
  } dir_class_e;

  // Mode switch codes
  localparam logic [1:0] SW_HALT = 2'h0;
  localparam logic [1:0] SW_RUN = 2'h1;
  localparam logic [1:0] SW_PRUN = 2'h2;

  // Engine states
  typedef enum logic [4:0] {
    E_BOOT = 5'h01,
    E_IDLE = 5'h02,
    E_SCAN = 5'h04,
    E_MAP = 5'h08,
    E_LOAD = 5'h10
  } engine_e;

  // Switch carrier
  typedef struct packed {
    logic memSelNv;
    logic [1:0] modeSw;
    logic cardPresent;
  } sw_s;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam logic [12:0] BOOT_CYCLES = 13'h0003; // Sync settle time
  localparam logic [1:0] SCAN_WAIT = 2'h3;  // Slot type settle cycles
  localparam logic [1:0] NV_WAIT = 2'h3;    // Storage word settle cycles
  localparam logic RST_WAIT = 1'b1;         // Waitrequest after reset
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

/* hdl/io_register_map_mode_gate.sv */
// Shared I/O image, allocation mapping, reload engine and mode gating.
// Assumes an Avalon-MM master on sys_clk, switch and module pins that are
// asynchronous, and storage that holds each addressed word steady.
`timescale 1ns/1ps
`default_nettype none

module io_register_map_mode_gate
  import io_map_pkg::*;
(
  input wire logic sys_clk,               // 100 MHz clock
  input wire logic rst_b,                 // Async reset, active low
  input wire logic memSelNv,              // Switch: 1 non-volatile
  input wire logic [1:0] modeSw,          // Mode switch code
  input wire logic cardPresent,           // Memory card fitted
  input wire logic [7:0] moduleType,      // Type of addressed slot
  input wire logic [15:0] nvData,         // Storage word
  input wire logic inWrEn,                // Batch input strobe
  input wire logic [7:0] inWrAddr,        // Batch input address
  input wire logic [15:0] inWrData,       // Batch input word
  input wire logic [14:0] avs_address,    // Byte address
  input wire logic avs_read,              // Read request
  input wire logic avs_write,             // Write request
  input wire logic [31:0] avs_writedata,  // Write data
  input wire logic [3:0] avs_byteenable,  // Byte lanes
  output logic [31:0] avs_readdata,       // Read data
  output logic avs_waitrequest,           // Stall
  output logic [5:0] scanSlot,            // Slot being typed
  output logic [12:0] nvAddr,             // Storage word address
  output logic nvCardSel,                 // 1 card, 0 built-in
  output logic runMode,                   // Running
  output logic protActive                 // Protected run selected
);

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rstMeta_q, rstSync_q, rstN;
  sw_s swMeta_q, swSync_q;
  logic [7:0] typeMeta_q, typeSync_q;
  logic [15:0] nvMeta_q, nvSync_q;

  // Release reset through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // Switch, type and storage pins pass two flops before any gating looks at them
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      swMeta_q <= '0;
      swSync_q <= '0;
      typeMeta_q <= 8'h00;
      typeSync_q <= 8'h00;
      nvMeta_q <= 16'h0000;
      nvSync_q <= 16'h0000;
    end else begin
      swMeta_q <= {memSelNv, modeSw, cardPresent};
      swSync_q <= swMeta_q;
      typeMeta_q <= moduleType;
      typeSync_q <= typeMeta_q;
      nvMeta_q <= nvData;
      nvSync_q <= nvMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Storage: one array for both image directions
  // ----------------------------------------------------------------
  logic [15:0] imageMem [IMG_WORDS];
  logic [15:0] dataMem [PROT_WORDS];
  logic [15:0] progMem [PROG_WORDS];
  logic [255:0] dirIn_q, dirIn_d;    // 1 input, 0 output
  engine_e engine_q, engine_d;
  logic run_q, run_d;
  logic prot, loadCond, allocOk;

  assign prot = swSync_q.modeSw == SW_PRUN;
  assign loadCond = swSync_q.memSelNv && !prot;
  assign allocOk = !run_q && !prot && engine_q == E_IDLE;

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic rej_q, rej_d;
  logic take, isData, beOk;
  logic [3:0] region;
  logic [7:0] idx;
  logic [11:0] dIdx;
  logic busImgWe, busDataWe, busProgWe, busRecWe, busRecRej;
  logic ctrlWr, cmdAuto, cmdRun, cmdHalt, rejClr;

  // Decode; one answer cycle only while the engine leaves memory alone
  always_comb begin
    take = (avs_read || avs_write) && wait_q && engine_q == E_IDLE;
    isData = avs_address[14];
    region = avs_address[13:10];
    idx = avs_address[9:2];
    dIdx = avs_address[13:2];
    beOk = |avs_byteenable[1:0];
    // Words held as input belong to the module side, not software
    busImgWe = take && avs_write && beOk && !isData &&
               region == REG_IMAGE && !dirIn_q[idx];
    busDataWe = take && avs_write && beOk && isData && !prot;
    busRecWe = take && avs_write && beOk && !isData &&
               region == REG_PROG && int'(idx) < NSLOT && allocOk;
    busRecRej = take && avs_write && !isData && region == REG_PROG &&
                int'(idx) < NSLOT && !allocOk;
    busProgWe = busRecWe || (take && avs_write && beOk && !isData &&
                region == REG_PROG && int'(idx) >= NSLOT);
    ctrlWr = take && avs_write && beOk && !isData && region == REG_CTL;
    cmdAuto = ctrlWr && idx == CTL_WORD && avs_writedata[CTL_AUTO];
    cmdRun = ctrlWr && idx == CTL_WORD && avs_writedata[CTL_RUN];
    cmdHalt = ctrlWr && idx == CTL_WORD && avs_writedata[CTL_HALT];
    rejClr = ctrlWr && idx == STAT_WORD && avs_writedata[STAT_REJ];
    // Sticky reject flag; a new reject beats a clear
    rej_d = rej_q;
    if (rejClr) begin
      rej_d = 1'b0;
    end
    if (busRecRej || (cmdAuto && !allocOk)) begin
      rej_d = 1'b1;
    end
    wait_d = !take;
    rdata_d = rdata_q;
    if (take) begin
      rdata_d = 32'h0000_0000; // Unmapped reads as zero
      if (isData) begin
        rdata_d[15:0] = dataMem[dIdx];
      end else if (region == REG_IMAGE) begin
        rdata_d[15:0] = imageMem[idx];
      end else if (region == REG_DIR) begin
        rdata_d[0] = dirIn_q[idx];
      end else if (region == REG_PROG) begin
        rdata_d[15:0] = progMem[idx];
      end else if (region == REG_CTL && idx == STAT_WORD) begin
        rdata_d[STAT_RUN] = run_q;
        rdata_d[STAT_PROT] = prot;
        rdata_d[STAT_BUSY] = engine_q != E_IDLE;
        rdata_d[STAT_REJ] = rej_q;
        rdata_d[STAT_NV] = swSync_q.memSelNv;
      end
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wait_q <= RST_WAIT;
      rdata_q <= RST_RDATA;
      rej_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      rej_q <= rej_d;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // Engine: boot, scan, map, reload and run/halt control
  // ----------------------------------------------------------------
  logic [12:0] cnt_q, cnt_d;
  logic [1:0] wt_q, wt_d;
  logic [8:0] base_q, base_d;
  logic [3:0] word_q, word_d;
  logic goRun_q, goRun_d, card_q, card_d;
  logic [1:0] swPrev_q, swPrev_d;
  logic engProgWe, engDataWe, toRun, toHalt;
  logic [15:0] rec;
  dir_class_e cls;
  logic [3:0] words;
  logic [12:0] dOff;

  always_comb begin
    engine_d = engine_q;
    cnt_d = cnt_q;
    wt_d = wt_q;
    base_d = base_q;
    word_d = word_q;
    goRun_d = goRun_q;
    card_d = card_q;
    run_d = run_q;
    dirIn_d = dirIn_q;
    swPrev_d = swSync_q.modeSw;
    engProgWe = 1'b0;
    engDataWe = 1'b0;
    rec = progMem[cnt_q[7:0]];
    cls = dir_class_e'(rec[7:6]);
    // Word count from the type; special and classless take none
    words = (rec[TYPE_SPECIAL] || cls == CLS_NONE) ? 4'h0 : rec[3:0];
    dOff = cnt_q - 13'(PROG_WORDS);
    toRun = !run_q && (cmdRun ||
            (swSync_q.modeSw == SW_RUN && swPrev_q == SW_HALT));
    toHalt = cmdHalt ||
             (swSync_q.modeSw == SW_HALT && swPrev_q != SW_HALT);
    unique case (engine_q)
      E_BOOT: begin
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q == BOOT_CYCLES) begin
          cnt_d = 13'h0000;
          wt_d = 2'h0;
          goRun_d = swSync_q.memSelNv && swSync_q.modeSw != SW_HALT;
          card_d = swSync_q.cardPresent;
          if (loadCond) begin
            engine_d = E_LOAD;
          end else begin
            engine_d = E_IDLE;
            run_d = goRun_d;
          end
        end
      end
      E_IDLE: begin
        if (cmdAuto && allocOk) begin
          engine_d = E_SCAN;
          cnt_d = 13'h0000;
          wt_d = 2'h0;
        end else if (toHalt) begin
          run_d = 1'b0;
        end else if (toRun && loadCond) begin
          engine_d = E_LOAD;
          cnt_d = 13'h0000;
          wt_d = 2'h0;
          goRun_d = 1'b1;
          card_d = swSync_q.cardPresent;
        end else if (toRun) begin
          run_d = 1'b1;
        end else if (busRecWe) begin
          engine_d = E_MAP;
          wt_d = 2'h0;
        end
      end
      E_SCAN: begin
        wt_d = wt_q + 2'h1;
        if (wt_q == SCAN_WAIT) begin
          engProgWe = 1'b1;
          wt_d = 2'h0;
          cnt_d = cnt_q + 13'h0001;
          if (int'(cnt_q) == NSLOT - 1) begin
            engine_d = E_MAP;
          end
        end
      end
      E_MAP: begin
        if (wt_q == 2'h0) begin
          dirIn_d = '0;
          wt_d = 2'h1;
          cnt_d = 13'h0000;
          base_d = 9'h000;
          word_d = 4'h0;
        end else if (word_q < words && int'(base_q) < IMG_WORDS) begin
          // Mixed modules: lower half input, upper half output
          dirIn_d[base_q[7:0]] = cls == CLS_IN ||
            (cls == CLS_MIX && word_q < (words >> 1));
          base_d = base_q + 9'h001;
          word_d = word_q + 4'h1;
        end else begin
          word_d = 4'h0;
          cnt_d = cnt_q + 13'h0001;
          if (int'(cnt_q) == NSLOT - 1) begin
            engine_d = E_IDLE;
          end
        end
      end
      E_LOAD: begin
        wt_d = wt_q + 2'h1;
        if (wt_q == NV_WAIT) begin
          wt_d = 2'h0;
          // Retentive settings do not spare data words from the copy
          engProgWe = int'(cnt_q) < PROG_WORDS;
          engDataWe = int'(cnt_q) >= PROG_WORDS;
          cnt_d = cnt_q + 13'h0001;
          if (int'(cnt_q) == LOAD_WORDS - 1) begin
            engine_d = E_MAP;
            run_d = goRun_q;
          end
        end
      end
    endcase
  end

  // Engine registers; image starts all output
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      engine_q <= E_BOOT;
      cnt_q <= 13'h0000;
      wt_q <= 2'h0;
      base_q <= 9'h000;
      word_q <= 4'h0;
      goRun_q <= 1'b0;
      card_q <= 1'b0;
      run_q <= 1'b0;
      dirIn_q <= '0;
      swPrev_q <= SW_HALT;
    end else begin
      engine_q <= engine_d;
      cnt_q <= cnt_d;
      wt_q <= wt_d;
      base_q <= base_d;
      word_q <= word_d;
      goRun_q <= goRun_d;
      card_q <= card_d;
      run_q <= run_d;
      dirIn_q <= dirIn_d;
      swPrev_q <= swPrev_d;
    end
  end

  // ----------------------------------------------------------------
  // Memory writes; bus and engine never write in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (busImgWe) begin
      imageMem[idx] <= avs_writedata[15:0];
    end else if (inWrEn && dirIn_q[inWrAddr]) begin
      imageMem[inWrAddr] <= inWrData;
    end
    if (busDataWe) begin
      dataMem[dIdx] <= avs_writedata[15:0];
    end else if (engDataWe) begin
      dataMem[dOff[11:0]] <= nvSync_q;
    end
    if (busProgWe) begin
      progMem[idx] <= avs_writedata[15:0];
    end else if (engProgWe && engine_q == E_SCAN) begin
      progMem[cnt_q[7:0]] <= {8'h00, typeSync_q};
    end else if (engProgWe) begin
      progMem[cnt_q[7:0]] <= nvSync_q;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [5:0] slot_q;
  logic [12:0] nva_q;
  logic prot_q;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      slot_q <= 6'h00;
      nva_q <= 13'h0000;
      prot_q <= 1'b0;
    end else begin
      slot_q <= engine_d == E_SCAN ? cnt_d[5:0] : 6'h00;
      nva_q <= engine_d == E_LOAD ? cnt_d : 13'h0000;
      prot_q <= prot;
    end
  end
  assign scanSlot = slot_q;
  assign nvAddr = nva_q;
  assign nvCardSel = card_q;
  assign runMode = run_q;
  assign protActive = prot_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  boot_halt_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    engine_q == E_BOOT && engine_d == E_IDLE && !swSync_q.memSelNv
    |=> !run_q) else $error("volatile boot did not halt");
  prot_write_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    take && avs_write && isData && prot |=>
    dataMem[$past(dIdx)] == $past(dataMem[dIdx]))
    else $error("protected data word written");
  load_gate_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    engine_d == E_LOAD && engine_q != E_LOAD |-> loadCond)
    else $error("reload started while gated off");
  load_len_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    engine_q == E_LOAD && engine_d == E_MAP
    |-> int'(cnt_q) == LOAD_WORDS - 1 && engDataWe)
    else $error("reload ended early");
  alloc_gate_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    busRecWe || (engine_q == E_IDLE && engine_d == E_SCAN)
    |-> !run_q && !prot) else $error("allocation accepted while gated");
  scan_map_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    engine_q == E_SCAN && engine_d == E_MAP |=> engine_q == E_MAP ##1
    dirIn_q == '0) else $error("mapping did not follow scan");
  special_skip_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    engine_q == E_MAP && wt_q != 2'h0 && rec[TYPE_SPECIAL]
    |=> $stable(base_q)) else $error("special module took a register");
  wait_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    $fell(wait_q) |=> wait_q) else $error("waitrequest low too long");
  rej_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    busRecRej |=> rej_q) else $error("reject not flagged");

endmodule

`default_nettype wire

/* tb/io_far_side.sv */
// Far-side model: the mounted modules and the non-volatile storage.
// Assumes scanSlot and nvAddr come registered from the block.
`timescale 1ns/1ps
`default_nettype none

module io_far_side
  import io_map_pkg::*;
(
  input wire logic [5:0] scanSlot, // Slot being typed
  input wire logic [12:0] nvAddr, // Storage word index
  input wire logic nvCardSel, // 1 card, 0 built-in
  output logic [7:0] moduleType, // Type of addressed slot
  output logic [15:0] nvData // Storage word
);
  // ----------------------------------------------------------------
  // Mounted modules
  // ----------------------------------------------------------------
  // Class in 7:6, special in 5, word count in 3:0
  always_comb begin
    case (scanSlot)
      6'h00: moduleType = 8'h42;
      6'h01: moduleType = 8'h81;
      6'h02: moduleType = 8'h64;
      6'h03: moduleType = 8'hC2;
      default: moduleType = 8'h00; // Vacant slot
    endcase
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Top nibble tells card from built-in, so a wrong source shows
  assign nvData = {nvCardSel ? 4'hC : 4'hB, nvAddr[11:0]};
endmodule

`default_nettype wire

/* tb/test_io_register_map_mode_gate.sv */
// Self-checking bench for the I/O image and mode gate.
// Assumes the far-side model answers module types and storage words.
`timescale 1ns/1ps
`default_nettype none

module test_io_register_map_mode_gate;
  import io_map_pkg::*;
  localparam logic [14:0] CTL = 15'h0C00; // Command word
  localparam logic [14:0] STAT = 15'h0C04; // Status word
  logic sys_clk = 1'b0, rst_b = 1'b0, memSelNv = 1'b0, cardPresent = 1'b0;
  logic inWrEn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0] modeSw = SW_RUN; // Run at power-up on purpose
  logic [7:0] moduleType, inWrAddr = 8'h00;
  logic [15:0] nvData, r, inWrData = 16'h0000;
  logic [14:0] avs_address = 15'h0000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic avs_waitrequest, nvCardSel, runMode, protActive;
  logic [3:0] byteLanes = 4'hF; // Byte lanes of the next request
  logic [5:0] scanSlot;
  logic [12:0] nvAddr;
  int err_total = 0, cmp_count = 0;
  int types[44]; // Reference slot types
  int expDir[256]; // Reference direction per word

  always #5 sys_clk = ~sys_clk;

  io_register_map_mode_gate DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .memSelNv(memSelNv), .modeSw(modeSw), .cardPresent(cardPresent),
    .moduleType(moduleType), .nvData(nvData), .inWrEn(inWrEn),
    .inWrAddr(inWrAddr), .inWrData(inWrData), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(byteLanes),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scanSlot(scanSlot), .nvAddr(nvAddr), .nvCardSel(nvCardSel),
    .runMode(runMode), .protActive(protActive));

  io_far_side farSide (.scanSlot(scanSlot), .nvAddr(nvAddr),
    .nvCardSel(nvCardSel), .moduleType(moduleType), .nvData(nvData));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task conclude;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  // Holds the request until waitrequest is seen low; bounded wait
  task bus(input logic wr, input logic [14:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 30000) begin
        err_total++;
        conclude();
      end
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task rd(input logic [14:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask

  // ----------------------------------------------------------------
  // Reference mapping: nearest slot first, ascending addresses
  // ----------------------------------------------------------------
  task mapModel;
    int a, c, n;
    a = 0;
    foreach (expDir[i]) expDir[i] = 0;
    for (int s = 0; s < 44; s++) begin
      c = types[s] >> 6;
      n = types[s] & 15;
      // Special and vacant slots take no words
      if (c != 0 && (types[s] & 32) == 0) begin
        for (int k = 0; k < n; k++) begin
          if (a < 256) expDir[a] = (c == 1 || (c == 3 && k < n / 2));
          a++;
        end
      end
    end
    for (int i = 0; i < 8; i++) begin
      rd(15'h0400 + 15'(4 * i), 16'(expDir[i]));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(86711));
    foreach (types[i]) types[i] = 0;
    types[0] = 8'h42;
    types[1] = 8'h81;
    types[2] = 8'h64;
    types[3] = 8'hC2;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk(32'(runMode), 32'h0000_0000);
    rd(STAT, 16'h0000);
    $display("power-up test done");
    r = 16'($urandom);
    bus(1'b1, 15'h03FC, r);
    // Upper lanes only: the word must not change
    byteLanes <= 4'hC;
    bus(1'b1, 15'h03FC, ~r);
    byteLanes <= 4'hF;
    rd(15'h03FC, r);
    rd(15'h07FC, 16'h0000);
    rd(15'h0C08, 16'h0000); // Unmapped place
    $display("image test done");
    bus(1'b1, CTL, 16'h0001);
    rd(15'h0800, 16'h0042);
    mapModel;
    r = 16'($urandom);
    bus(1'b1, 15'h0008, 16'hA5A5); // Output word written
    inWrAddr <= 8'h00;
    inWrData <= r;
    inWrEn <= 1'b1;
    @(posedge sys_clk);
    inWrAddr <= 8'h02;
    inWrData <= ~r;
    @(posedge sys_clk);
    inWrEn <= 1'b0;
    bus(1'b1, 15'h0000, ~r); // Input word, bus write ignored
    rd(15'h0000, r);
    rd(15'h0008, 16'hA5A5);
    $display("allocation test done");
    bus(1'b1, 15'h401C, 16'h1234); // Halted, data word open
    modeSw <= SW_PRUN;
    repeat (5) @(posedge sys_clk);
    chk(32'(protActive), 32'h0000_0001);
    bus(1'b1, 15'h401C, 16'h5678);
    bus(1'b1, CTL, 16'h0001);
    // Record write while protected: refused, record kept
    bus(1'b1, 15'h0800, 16'h00FF);
    rd(15'h0800, 16'h0042);
    rd(15'h401C, 16'h1234);
    rd(STAT, 16'h000A);
    bus(1'b1, STAT, 16'h0008); // Clear sticky reject
    modeSw <= SW_HALT;
    repeat (5) @(posedge sys_clk);
    rd(STAT, 16'h0000);
    $display("protect test done");
    bus(1'b1, 15'h0800, 16'h0081);
    types[0] = 8'h81;
    mapModel;
    $display("manual test done");
    cardPresent <= 1'b1;
    memSelNv <= 1'b1;
    repeat (5) @(posedge sys_clk);
    modeSw <= SW_RUN; // Halt to run edge
    repeat (5) @(posedge sys_clk);
    rd(15'h401C, 16'hC107);
    rd(15'h7FFC, 16'hC0FF);
    chk(32'(runMode), 32'h0000_0001);
    rd(STAT, 16'h0011);
    // Protected run only once the run flag is seen
    modeSw <= SW_PRUN;
    repeat (5) @(posedge sys_clk);
    rd(STAT, 16'h0013);
    $display("reload test done");
    // Second power-up: non-volatile, no card, so built-in source
    rst_b <= 1'b0;
    modeSw <= SW_RUN;
    cardPresent <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(15'h401C, 16'hB107);
    chk(32'(runMode), 32'h0000_0001);
    $display("second power-up test done");
    conclude();
  end
endmodule

`default_nettype wire
